// ===== via_params.svh
// offsets, field positions, reset values and vectors of the interrupt arbiter
`ifndef VIA_PARAMS_SVH
`define VIA_PARAMS_SVH

`define VIA_OFS_REQ        8'h00
`define VIA_OFS_MASK       8'h04
`define VIA_OFS_PRIO       8'h08
`define VIA_OFS_EDGE       8'h0C
`define VIA_OFS_PSW        8'h10
`define VIA_OFS_LVDC       8'h14
`define VIA_OFS_EVSTAT     8'h18
`define VIA_OFS_EVEN       8'h1C

`define VIA_REQ_RST        32'h0000_0000
`define VIA_MASK_RST       32'hDFFF_FFFF
`define VIA_PRIO_RST       32'hFFFF_FFFF
`define VIA_SRC_VALID      32'h19FC_1E5F
`define VIA_INT_VALID      32'h19FC_1E00
`define VIA_LVI_BIT        0
`define VIA_LVRS_BIT       1
`define VIA_PSW_IE_BIT     7
`define VIA_PSW_ISP_BIT    3
`define VIA_PSW_RST        8'h08
`define VIA_FALL_LSB       8

`define VIA_VEC_BASE       16'h0004
`define VIA_VEC_BRK        16'h003E
`define VIA_VEC_RESET      16'h0000

`define VIA_EV_ACK         0
`define VIA_EV_BRK         1
`define VIA_EV_RST         2

`endif

// ===== via_pkg.sv
// types shared by the interrupt arbiter
`default_nettype none
package via_pkg;
  // vector offered to the cpu core
  typedef struct packed {
    logic        valid;
    logic [15:0] vector;
  } via_vec_t;
endpackage : via_pkg
`default_nettype wire

// ===== via_arbiter.sv
// vectored interrupt arbiter with apb register access
`default_nettype none
`include "via_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - among pending maskable requests those with priority flag 0 go first, then the lowest default priority number wins, 0 first.
// - the empty vector slots are never produced since their flag bits cannot be set.
// - a low-voltage event is a reset source only while the reset-select bit is 1.
// - request, mask, priority, rising-edge, falling-edge and status-word registers steer it.
// - each source has one request, one mask and one priority bit at the same position.
// - rising and falling edge detection of each pin is enabled separately.
// - pins 0 to 3 and 5 pass edge detection, internal sources set flags directly.
// - pins 0 to 3 vector to 0006H..000CH and pin 5 to 0010H.
// - acknowledging a request clears its request flag.
// - reset masks all sources, the top mask byte reading DFH.
module via_arbiter
  import via_pkg::*;
#(
  parameter int EXT_W = 6
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic             pready_out,
  output logic [31:0]      prdata_out,
  output logic             pslverr_out,
  input  wire logic [EXT_W-1:0] ext_pin_in,
  input  wire logic [31:0] int_src_in,
  input  wire logic        low_voltage_detect_in,
  input  wire logic        power_on_clear_in,
  input  wire logic        watchdog_overflow_source_in,
  input  wire logic        break_instruction_in,
  input  wire logic        int_ack_in,
  output var via_vec_t     int_req_out,
  output var via_vec_t     special_vec_out,
  output logic             reset_req_out,
  output logic             irq_out
);

  // pins 0..3 and 5 are decoded and the falling-edge enables end at bit 15
  if (EXT_W < 6 || EXT_W > 8) begin : g_chk
    $error("EXT_W must be 6 to 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [31:0]      req_q;
  logic [31:0]      req_d;
  logic [31:0]      mask_q;
  logic [31:0]      prio_q;
  logic [15:0]      edge_q;
  logic [7:0]       psw_q;
  logic [7:0]       psw_d;
  logic [7:0]       lvdc_q;
  logic [2:0]       evstat_q;
  logic [2:0]       even_q;
  logic [EXT_W-1:0] pin_q;
  logic [4:0]       grant_q;
  logic [4:0]       grant_d;
  logic             found_d;
  logic             rst_pend_q;
  logic [2:0]       ev_set;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic        wr_en;
  logic        rd_en;
  logic        mapped;
  logic [31:0] rd_mux;
  logic [31:0] lane_mask;

  assign wr_en = psel_in & penable_in & pwrite_in;
  assign rd_en = psel_in & penable_in & ~pwrite_in;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_mask[i*8 +: 8] = {8{pstrb_in[i]}};
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] lm);
    merge = (old & ~lm) | (nw & lm);
  endfunction : merge

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr_in)
      `VIA_OFS_REQ:    rd_mux = req_q;
      `VIA_OFS_MASK:   rd_mux = mask_q;
      `VIA_OFS_PRIO:   rd_mux = prio_q;
      `VIA_OFS_EDGE:   rd_mux = {16'h0000, edge_q};
      `VIA_OFS_PSW:    rd_mux = {24'h00_0000, psw_q};
      `VIA_OFS_LVDC:   rd_mux = {24'h00_0000, lvdc_q};
      `VIA_OFS_EVSTAT: rd_mux = {29'h0000_0000, evstat_q};
      `VIA_OFS_EVEN:   rd_mux = {29'h0000_0000, even_q};
      default:         mapped = 1'b0;
    endcase
  end

  // zero wait state; unmapped addresses answer with an error and read zero
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~mapped;
  assign prdata_out  = rd_en ? rd_mux : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // edge detection on the external pins
  logic [EXT_W-1:0] rise;
  logic [EXT_W-1:0] fall;
  logic [EXT_W-1:0] pin_edge;
  logic [31:0]      ext_set;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pin_q <= '0;
    end else begin
      pin_q <= ext_pin_in;
    end
  end

  always_comb begin
    for (int i = 0; i < EXT_W; i++) begin
      rise[i]     = ext_pin_in[i] & ~pin_q[i] & edge_q[i];
      fall[i]     = ~ext_pin_in[i] & pin_q[i] & edge_q[`VIA_FALL_LSB + i];
      pin_edge[i] = rise[i] | fall[i];
    end
  end

  // pins 0..3 land on flag bits 1..4, pin 5 on bit 6; pin 4 has no source
  assign ext_set = {25'h000_0000, pin_edge[5], 1'b0, pin_edge[3:0], 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // request flags
  logic [31:0] hw_set;
  logic        lv_reset;
  logic        ack_take;

  assign lv_reset = low_voltage_detect_in & lvdc_q[`VIA_LVRS_BIT];
  assign ack_take = int_ack_in & int_req_out.valid;

  always_comb begin
    hw_set = ext_set | (int_src_in & `VIA_INT_VALID);
    hw_set[`VIA_LVI_BIT] = low_voltage_detect_in & ~lvdc_q[`VIA_LVRS_BIT];
  end

  always_comb begin
    req_d = req_q;
    if (wr_en && paddr_in == `VIA_OFS_REQ) begin
      req_d = merge(req_q, pwdata_in, lane_mask);
    end
    if (ack_take) begin
      req_d[grant_q] = 1'b0;
    end
    // a new request in the clearing cycle is kept
    req_d = (req_d | hw_set) & `VIA_SRC_VALID;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      req_q <= `VIA_REQ_RST;
    end else begin
      req_q <= req_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mask, priority, edge enables, low-voltage control
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      mask_q <= `VIA_MASK_RST;
    end else if (wr_en && paddr_in == `VIA_OFS_MASK) begin
      mask_q <= merge(mask_q, pwdata_in, lane_mask);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      prio_q <= `VIA_PRIO_RST;
    end else if (wr_en && paddr_in == `VIA_OFS_PRIO) begin
      prio_q <= merge(prio_q, pwdata_in, lane_mask);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      edge_q <= 16'h0000;
    end else if (wr_en && paddr_in == `VIA_OFS_EDGE) begin
      edge_q <= 16'(merge({16'h0000, edge_q}, pwdata_in,
                          lane_mask));
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      lvdc_q <= 8'h00;
    end else if (wr_en && paddr_in == `VIA_OFS_LVDC && pstrb_in[0]) begin
      lvdc_q <= pwdata_in[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program status word: global enable and in-service priority
  always_comb begin
    psw_d = psw_q;
    if (wr_en && paddr_in == `VIA_OFS_PSW && pstrb_in[0]) begin
      psw_d = pwdata_in[7:0];
    end
    if (ack_take) begin
      psw_d[`VIA_PSW_IE_BIT]  = 1'b0;
      psw_d[`VIA_PSW_ISP_BIT] = prio_q[grant_q];
    end else if (break_instruction_in) begin
      psw_d[`VIA_PSW_IE_BIT] = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      psw_q <= `VIA_PSW_RST;
    end else begin
      psw_q <= psw_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration on the next-state flags so an acknowledged source drops at once
  logic [31:0] pend;
  logic [31:0] pend_hi;

  assign pend    = req_d & ~mask_q & `VIA_SRC_VALID;
  assign pend_hi = pend & ~prio_q;

  function automatic logic [5:0] lowest(input logic [31:0] v);
    lowest = 6'h20;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        lowest = 6'(i);
      end
    end
  endfunction : lowest

  always_comb begin
    logic [5:0] sel;
    sel = 6'h20;
    if (|pend_hi) begin
      sel = lowest(pend_hi);
    end else if (psw_d[`VIA_PSW_ISP_BIT]) begin
      sel = lowest(pend);
    end
    found_d = ~sel[5] & psw_d[`VIA_PSW_IE_BIT];
    grant_d = sel[4:0];
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      grant_q     <= 5'h00;
      int_req_out <= '0;
    end else begin
      grant_q            <= grant_d;
      int_req_out.valid  <= found_d;
      int_req_out.vector <= `VIA_VEC_BASE + {10'h000, grant_d, 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // break and reset sources
  logic any_reset;

  assign any_reset = power_on_clear_in | watchdog_overflow_source_in | lv_reset;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rst_pend_q      <= 1'b1;
      reset_req_out   <= 1'b0;
      special_vec_out <= '0;
    end else begin
      rst_pend_q    <= 1'b0;
      reset_req_out <= any_reset;
      if (any_reset || rst_pend_q) begin
        special_vec_out <= '{valid: 1'b1, vector: `VIA_VEC_RESET};
      end else if (break_instruction_in) begin
        special_vec_out <= '{valid: 1'b1, vector: `VIA_VEC_BRK};
      end else begin
        special_vec_out <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event status, write one to clear, set wins
  always_comb begin
    ev_set                = 3'b000;
    ev_set[`VIA_EV_ACK]   = ack_take;
    ev_set[`VIA_EV_BRK]   = break_instruction_in;
    ev_set[`VIA_EV_RST]   = any_reset;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      evstat_q <= 3'b000;
    end else if (wr_en && paddr_in == `VIA_OFS_EVSTAT && pstrb_in[0]) begin
      evstat_q <= (evstat_q & ~pwdata_in[2:0]) | ev_set;
    end else begin
      evstat_q <= evstat_q | ev_set;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      even_q <= 3'b000;
    end else if (wr_en && paddr_in == `VIA_OFS_EVEN && pstrb_in[0]) begin
      even_q <= pwdata_in[2:0];
    end
  end

  assign irq_out = |(evstat_q & even_q);

endmodule : via_arbiter
`default_nettype wire

// ===== via_arbiter_props.sv
// assertion checker for the vectored interrupt arbiter
`default_nettype none
module via_arbiter_props
  import via_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic        pready_out,
  input wire logic [31:0] prdata_out,
  input wire logic        pslverr_out,
  input wire logic        low_voltage_detect_in,
  input wire logic        power_on_clear_in,
  input wire logic        watchdog_overflow_source_in,
  input wire logic        break_instruction_in,
  input wire logic        int_ack_in,
  input var  via_vec_t    int_req_out,
  input var  via_vec_t    special_vec_out,
  input wire logic        reset_req_out
);
  logic apb_acc;
  logic rst_src;
  assign apb_acc = psel_in && penable_in;
  assign rst_src = power_on_clear_in || watchdog_overflow_source_in;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  sequence ack_taken;
    int_req_out.valid && int_ack_in;
  endsequence
  sequence brk_only;
    break_instruction_in && !rst_src && !low_voltage_detect_in;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  apb_ready_a: assert property (apb_acc |-> pready_out)
    else $error("pready low in access phase");
  rdata_idle_a: assert property (!(apb_acc && !pwrite_in) |-> prdata_out == 32'h0000_0000)
    else $error("read data outside a read access");
  slverr_acc_a: assert property (pslverr_out |-> apb_acc)
    else $error("slave error outside access phase");
  vec_slot_a: assert property (int_req_out.valid |-> !int_req_out.vector[0] &&
    int_req_out.vector inside {[16'h0004:16'h000C], 16'h0010, [16'h0016:16'h001C],
    [16'h0028:16'h0034], 16'h003A, 16'h003C}) else $error("vector to an empty slot");
  ack_clear_a: assert property (ack_taken |=> !int_req_out.valid)
    else $error("request still offered after acknowledge");
  brk_vec_a: assert property (brk_only |=> special_vec_out.valid &&
    special_vec_out.vector == 16'h003E) else $error("break vector wrong");
  rst_vec_a: assert property (rst_src |=> reset_req_out && special_vec_out.valid &&
    special_vec_out.vector == 16'h0000) else $error("reset source vector wrong");
  lvd_cause_a: assert property (reset_req_out && !$past(rst_in) |->
    $past(power_on_clear_in) || $past(watchdog_overflow_source_in) ||
    $past(low_voltage_detect_in)) else $error("reset request without a source");
endmodule : via_arbiter_props

bind via_arbiter via_arbiter_props u_props (
  .mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .pready_out(pready_out), .prdata_out(prdata_out),
  .pslverr_out(pslverr_out), .low_voltage_detect_in(low_voltage_detect_in),
  .power_on_clear_in(power_on_clear_in),
  .watchdog_overflow_source_in(watchdog_overflow_source_in),
  .break_instruction_in(break_instruction_in), .int_ack_in(int_ack_in),
  .int_req_out(int_req_out), .special_vec_out(special_vec_out), .reset_req_out(reset_req_out)
);
`default_nettype wire

// ===== via_cpu_model.sv
// cpu core model that takes offered vectors after a set delay
`default_nettype none
module via_cpu_model
  import via_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  var  via_vec_t   int_req_in,
  input  wire logic [3:0] wait_in,
  output logic            ack_out,
  output logic [15:0]     taken_vec_out,
  output logic [7:0]      taken_cnt_out
);
  logic [3:0] delay_q;
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ack_out       <= 1'b0;
      delay_q       <= 4'h0;
      taken_vec_out <= 16'h0000;
      taken_cnt_out <= 8'h00;
    end else if (ack_out) begin
      ack_out       <= 1'b0;
      delay_q       <= 4'h0;
      taken_vec_out <= int_req_in.vector;
      taken_cnt_out <= taken_cnt_out + 8'h01;
    end else if (!int_req_in.valid) begin
      delay_q <= 4'h0;
    end else if (delay_q >= wait_in) begin
      ack_out <= 1'b1;
    end else begin
      delay_q <= delay_q + 4'h1;
    end
  end
endmodule : via_cpu_model
`default_nettype wire

// ===== via_arbiter_tb_top.sv
// self-checking testbench for the vectored interrupt arbiter
`default_nettype none
module via_arbiter_tb_top
  import via_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_in, rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [7:0]  paddr_in, taken_cnt;
  logic [31:0] pwdata_in, prdata_out, int_src_in, rd;
  logic [5:0]  ext_pin_in;
  logic        lvd, power_on_clear, wdt, break_instruction, ack, reset_req_out, irq_out, rr, err;
  logic [3:0]  cpu_wait;
  logic [15:0] taken_vec;
  via_vec_t    int_req_out, special_vec_out, sv;
  int          failures, samples_checked;

  via_arbiter DUT (.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(4'hF), .pready_out(pready_out), .prdata_out(prdata_out),
    .pslverr_out(pslverr_out), .ext_pin_in(ext_pin_in), .int_src_in(int_src_in),
    .low_voltage_detect_in(lvd), .power_on_clear_in(power_on_clear), .watchdog_overflow_source_in(wdt),
    .break_instruction_in(break_instruction), .int_ack_in(ack), .int_req_out(int_req_out),
    .special_vec_out(special_vec_out), .reset_req_out(reset_req_out), .irq_out(irq_out));
  via_cpu_model u_cpu (.mclk_in(mclk_in), .rst_in(rst_in), .int_req_in(int_req_out),
    .wait_in(cpu_wait), .ack_out(ack), .taken_vec_out(taken_vec), .taken_cnt_out(taken_cnt));

  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (n >= 50) begin
      failures++;
      wrap_up();
    end
    @(posedge mclk_in);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rd_chk
  // enable the cpu with both priority levels open, then wait for it to take one vector
  task automatic take(input logic [15:0] v);
    logic [7:0] c0;
    int n;
    c0 = taken_cnt;
    wr(8'h10, 32'h0000_0088);
    n = 0;
    while (taken_cnt === c0 && n < 100) begin
      @(posedge mclk_in);
      n++;
    end
    if (n >= 100) begin
      failures++;
      wrap_up();
    end
    check({16'h0000, taken_vec}, {16'h0000, v});
  endtask : take
  // one-cycle pulse of {break, watchdog, power-on, low-voltage}, outputs seen after it
  task automatic fire(input logic [3:0] s);
    @(posedge mclk_in);
    {break_instruction, wdt, power_on_clear, lvd} <= s;
    @(posedge mclk_in);
    {break_instruction, wdt, power_on_clear, lvd} <= 4'h0;
    #1;
    rr = reset_req_out;
    sv = special_vec_out;
    @(posedge mclk_in);
  endtask : fire
  task automatic pin(input logic [5:0] v, input logic [31:0] exp);
    ext_pin_in <= v;
    repeat (2) @(posedge mclk_in);
    rd_chk(8'h00, exp);
  endtask : pin
  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    @(negedge mclk_in);
    check({15'h0000, special_vec_out}, {15'h0000, 1'b1, 16'h0000});
    @(posedge mclk_in);
    rd_chk(8'h00, 32'h0000_0000);
    rd_chk(8'h04, 32'hDFFF_FFFF);
    rd_chk(8'h08, 32'hFFFF_FFFF);
    rd_chk(8'h10, 32'h0000_0008);
    rd_chk(8'h24, 32'h0000_0000);
    check({31'h0000_0000, err}, 32'h0000_0001);
  endtask : s_reset
  task automatic s_prio();
    wr(8'h04, 32'h0000_0000);
    wr(8'h08, 32'h0000_0000);
    int_src_in <= 32'h1004_4280;
    @(posedge mclk_in);
    int_src_in <= 32'h0000_0000;
    rd_chk(8'h00, 32'h1004_0200);
    take(16'h0016);
    take(16'h0028);
    take(16'h003C);
    rd_chk(8'h00, 32'h0000_0000);
  endtask : s_prio
  task automatic s_pins();
    cpu_wait <= 4'h3;
    wr(8'h0C, 32'h0000_2001);
    pin(6'h01, 32'h0000_0002);
    pin(6'h00, 32'h0000_0002);
    pin(6'h20, 32'h0000_0002);
    pin(6'h00, 32'h0000_0042);
    take(16'h0006);
    take(16'h0010);
  endtask : s_pins
  // priority flag beats default order; in-service priority follows the acknowledged source
  task automatic s_isp();
    wr(8'h08, 32'hEFFF_FFFF);
    int_src_in <= 32'h1800_0000;
    @(posedge mclk_in);
    int_src_in <= 32'h0000_0000;
    take(16'h003C);
    rd_chk(8'h10, 32'h0000_0000);
    take(16'h003A);
    rd_chk(8'h10, 32'h0000_0008);
  endtask : s_isp
  task automatic s_lvd();
    fire(4'h1);
    check({31'h0000_0000, rr}, 32'h0000_0000);
    rd_chk(8'h00, 32'h0000_0001);
    wr(8'h00, 32'h0000_0000);
    wr(8'h14, 32'h0000_0002);
    fire(4'h1);
    check({31'h0000_0000, rr}, 32'h0000_0001);
  endtask : s_lvd
  task automatic s_special();
    wr(8'h1C, 32'h0000_0002);
    for (int i = 0; i < 3; i++) begin
      fire(4'h8 >> i);
      check({15'h0000, sv}, {15'h0000, 1'b1, (i == 0) ? 16'h003E : 16'h0000});
      check({31'h0000_0000, rr}, {31'h0000_0000, i != 0});
      check({31'h0000_0000, irq_out}, {31'h0000_0000, i == 0});
      if (i == 0) wr(8'h18, 32'h0000_0002);
    end
    // acknowledge events from earlier scenarios stay set in bit 0
    rd_chk(8'h18, 32'h0000_0005);
  endtask : s_special
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    samples_checked = 0;
    rst_in = 1'b1;
    {psel_in, penable_in, pwrite_in, lvd, power_on_clear, wdt, break_instruction} = 7'h00;
    paddr_in = 8'h00;
    pwdata_in = 32'h0000_0000;
    int_src_in = 32'h0000_0000;
    ext_pin_in = 6'h00;
    cpu_wait = 4'h0;
    repeat (8) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    s_reset();
    s_prio();
    s_pins();
    s_isp();
    s_lvd();
    s_special();
    wrap_up();
  end
endmodule : via_arbiter_tb_top
`default_nettype wire
